// *** hdl/dvsc_pkg.sv ***
// Constants shared by the divide step control block
package dvsc_pkg;

	// ****************************************
	// Register map (APB byte addresses)
	// ****************************************
	localparam logic [7:0] DVSC_CTRL_OFS   = 8'h00;
	localparam logic [7:0] DVSC_ACC_OFS    = 8'h04;
	localparam logic [7:0] DVSC_QUOT_OFS   = 8'h08;
	localparam logic [7:0] DVSC_DIVS_OFS   = 8'h0C;
	localparam logic [7:0] DVSC_LINK_OFS   = 8'h10;
	localparam logic [7:0] DVSC_STATUS_OFS = 8'h14;

	// ****************************************
	// Field positions
	// ****************************************
	localparam int DVSC_CTRL_START_BIT = 0;
	localparam int DVSC_LINK_BIT       = 0;
	localparam int DVSC_ST_BUSY_BIT    = 0;
	localparam int DVSC_ST_OVF_BIT     = 1;
	localparam int DVSC_ST_SC_LSB      = 8;

	// ****************************************
	// Widths, step figures, reset values
	// ****************************************
	localparam int DVSC_WORD_W = 12;
	localparam int DVSC_SC_W   = 5;
	localparam logic [4:0] DVSC_SC_FIRST      = 5'h00;
	localparam logic [4:0] DVSC_SC_ACC_HOLD   = 5'h0C;
	localparam logic [4:0] DVSC_SC_LAST       = 5'h0D;
	localparam logic [11:0] DVSC_WORD_RST     = 12'h000;
	localparam logic [4:0] DVSC_SC_RST        = 5'h00;
	localparam int DVSC_STEP_DIV_CYC          = 4;

	typedef enum logic {
		DVSC_IDLE,
		DVSC_RUN
	} dvsc_state_t;

endpackage

// *** hdl/dvsc_step_timer.sv ***
// Step timing generator: one-cycle step pulse every DIV clocks while running
`timescale 1ns/1ps
`default_nettype none
module dvsc_step_timer
	import dvsc_pkg::*;
#(
	parameter int DIV = DVSC_STEP_DIV_CYC
) (
	// Clock and reset
	input  wire logic pclk,
	input  wire logic presetn,
	// Control
	input  wire logic run,
	output logic      step_tick
);

	initial begin
		if (DIV < 1 || DIV > 255) begin
			$error("step divider out of range");
		end
	end

	typedef struct packed {
		logic [7:0] cnt;
		logic       tick;
	} dvsc_tmr_t;

	dvsc_tmr_t r_r;
	dvsc_tmr_t r_nxt;

	// Stopped timer restarts from zero, so each divide starts on a clean period
	always_comb begin
		r_nxt = r_r;
		if (!run) begin
			r_nxt.cnt  = 8'h00;
			r_nxt.tick = 1'b0;
		end else if (r_r.cnt == 8'(DIV - 1)) begin
			r_nxt.cnt  = 8'h00;
			r_nxt.tick = 1'b1;
		end else begin
			r_nxt.cnt  = r_r.cnt + 8'h01;
			r_nxt.tick = 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			r_r.cnt  <= 8'h00;
			r_r.tick <= 1'b0;
		end else begin
			r_r <= r_nxt;
		end
	end

	always_comb begin
		step_tick = r_r.tick;
	end

endmodule
`default_nettype wire

// *** hdl/dvsc_divide_ctrl.sv ***
// Non-restoring 24/12 divide step control with APB register access
`timescale 1ns/1ps
`default_nettype none
module dvsc_divide_ctrl
	import dvsc_pkg::*;
#(
	parameter int STEP_DIV = DVSC_STEP_DIV_CYC
) (
	// Clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// Host processor side
	output logic             busy,
	output logic             host_resume
);

	initial begin
		if (STEP_DIV < 1 || STEP_DIV > 255) begin
			$error("step divide count out of range");
		end
	end

	// ****************************************
	// State
	// ****************************************
	typedef struct packed {
		dvsc_state_t  state;
		logic [11:0]  acc;
		logic [11:0]  quotient_reg;
		logic [11:0]  divisor;
		logic         link;
		logic [4:0]   step_count;
		logic         ovf;
		logic [31:0]  rdata;
		logic         ready;
		logic         slverr;
		logic         resume;
		logic         busy;
	} dvsc_regs_t;

	dvsc_regs_t r_r;
	dvsc_regs_t r_nxt;

	logic step_tick;

	// Timer idles cleared, so every divide starts on a full step period
	dvsc_step_timer #(
		.DIV (STEP_DIV)
	) u_timer (
		.pclk      (pclk),
		.presetn   (presetn),
		.run       (r_r.state == DVSC_RUN),
		.step_tick (step_tick)
	);

	// ****************************************
	// Divide datapath
	// ****************************************
	logic        first_op;
	logic        last_op;
	logic        accumulator_gate;
	logic        acc_comp;
	logic        divisor_gate;
	logic [11:0] add_a;
	logic [11:0] add_b;
	logic [12:0] add_sum;
	logic        adder_link_out;
	logic        div_overflow;
	logic        div_last;
	logic        quotient_top_pass;
	logic        acc_in_bit;
	logic        quot_in_bit;

	always_comb begin
		first_op         = (r_r.step_count == DVSC_SC_FIRST);
		last_op          = (r_r.step_count == DVSC_SC_LAST);
		accumulator_gate = 1'b1;
		// Accumulator is complemented rather than the divisor
		if (first_op) begin
			acc_comp = 1'b1;
		end else if (last_op) begin
			acc_comp = r_r.quotient_reg[1];
		end else begin
			acc_comp = r_r.quotient_reg[1] ^ r_r.quotient_reg[0];
		end
		divisor_gate = !(last_op && r_r.quotient_reg[0]);
		add_a        = acc_comp ? ~r_r.acc : r_r.acc;
		add_b        = divisor_gate ? r_r.divisor : DVSC_WORD_RST;
		add_sum      = {1'b0, add_a} + {1'b0, add_b};
		// Link enters the link stage along with the accumulator
		adder_link_out = (accumulator_gate & r_r.link) ^ add_sum[12];
		div_overflow   = first_op && adder_link_out;
		div_last       = last_op || div_overflow;
		// Top quotient bit crosses inverted while subtracting
		quotient_top_pass = (r_r.quotient_reg[0] == r_r.quotient_reg[11]);
		acc_in_bit        = !first_op && !quotient_top_pass;
		quot_in_bit       = first_op ? 1'b0 : (adder_link_out ^ r_r.quotient_reg[0]);
	end

	// ****************************************
	// Next state
	// ****************************************
	logic        apb_access;
	logic        apb_commit;
	logic        addr_ok;
	logic [31:0] rd_mux;

	always_comb begin
		r_nxt      = r_r;
		apb_access = psel && penable && !r_r.ready;
		apb_commit = psel && penable && r_r.ready;
		addr_ok    = (paddr == DVSC_CTRL_OFS) || (paddr == DVSC_ACC_OFS)
			|| (paddr == DVSC_QUOT_OFS) || (paddr == DVSC_DIVS_OFS)
			|| (paddr == DVSC_LINK_OFS) || (paddr == DVSC_STATUS_OFS);
		rd_mux = 32'h0000_0000;
		unique case (paddr)
			DVSC_ACC_OFS: begin
				rd_mux[11:0] = r_r.acc;
			end
			DVSC_QUOT_OFS: begin
				rd_mux[11:0] = r_r.quotient_reg;
			end
			DVSC_DIVS_OFS: begin
				rd_mux[11:0] = r_r.divisor;
			end
			DVSC_LINK_OFS: begin
				rd_mux[DVSC_LINK_BIT] = r_r.link;
			end
			DVSC_STATUS_OFS: begin
				rd_mux[DVSC_ST_BUSY_BIT] = (r_r.state == DVSC_RUN);
				rd_mux[DVSC_ST_OVF_BIT]  = r_r.ovf;
				rd_mux[DVSC_ST_SC_LSB +: DVSC_SC_W] = r_r.step_count;
			end
			default: begin
				rd_mux = 32'h0000_0000;
			end
		endcase

		// Bus: one wait cycle, then pready for one cycle
		r_nxt.ready  = apb_access;
		r_nxt.slverr = apb_access && !addr_ok;
		if (apb_access && !pwrite) begin
			r_nxt.rdata = rd_mux;
		end
		r_nxt.resume = 1'b0;

		unique case (r_r.state)
			DVSC_IDLE: begin
				// Operand writes land only while no divide runs
				if (apb_commit && pwrite) begin
					unique case (paddr)
						DVSC_ACC_OFS: begin
							r_nxt.acc = pwdata[11:0];
						end
						DVSC_QUOT_OFS: begin
							r_nxt.quotient_reg = pwdata[11:0];
						end
						DVSC_DIVS_OFS: begin
							r_nxt.divisor = pwdata[11:0];
						end
						DVSC_LINK_OFS: begin
							r_nxt.link = pwdata[DVSC_LINK_BIT];
						end
						DVSC_CTRL_OFS: begin
							if (pwdata[DVSC_CTRL_START_BIT]) begin
								r_nxt.state      = DVSC_RUN;
								r_nxt.step_count = DVSC_SC_RST;
								r_nxt.ovf        = 1'b0;
							end
						end
						default: begin
						end
					endcase
				end
			end
			DVSC_RUN: begin
				if (step_tick) begin
					r_nxt.step_count = r_r.step_count + 5'h01;
					if (div_overflow) begin
						r_nxt.state  = DVSC_IDLE;
						r_nxt.link   = 1'b1;
						r_nxt.ovf    = 1'b1;
						r_nxt.resume = 1'b1;
					end else if (last_op) begin
						r_nxt.step_count = r_r.step_count;
						r_nxt.acc        = add_sum[11:0];
						r_nxt.link       = 1'b0;
						r_nxt.state      = DVSC_IDLE;
						r_nxt.resume     = 1'b1;
					end else if (r_r.step_count == DVSC_SC_ACC_HOLD) begin
						r_nxt.acc          = add_sum[11:0];
						r_nxt.link         = adder_link_out;
						r_nxt.quotient_reg = {r_r.quotient_reg[10:0], quot_in_bit};
					end else begin
						r_nxt.acc          = {add_sum[10:0], acc_in_bit};
						r_nxt.link         = adder_link_out;
						r_nxt.quotient_reg = {r_r.quotient_reg[10:0], quot_in_bit};
					end
				end
			end
		endcase
		// Busy leaves a flop so the host never sees a decode glitch
		r_nxt.busy = (r_nxt.state == DVSC_RUN);
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			r_r.state        <= DVSC_IDLE;
			r_r.acc          <= DVSC_WORD_RST;
			r_r.quotient_reg <= DVSC_WORD_RST;
			r_r.divisor      <= DVSC_WORD_RST;
			r_r.link         <= 1'b0;
			r_r.step_count   <= DVSC_SC_RST;
			r_r.ovf          <= 1'b0;
			r_r.rdata        <= 32'h0000_0000;
			r_r.ready        <= 1'b0;
			r_r.slverr       <= 1'b0;
			r_r.resume       <= 1'b0;
			r_r.busy         <= 1'b0;
		end else begin
			r_r <= r_nxt;
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	always_comb begin
		prdata      = r_r.rdata;
		pready      = r_r.ready;
		pslverr     = r_r.slverr;
		busy        = r_r.busy;
		host_resume = r_r.resume;
	end

	// ****************************************
	// Assertions
	// ****************************************
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	sc_clear_a: assert property (
		(r_r.state == DVSC_IDLE) && apb_commit && pwrite && (paddr == DVSC_CTRL_OFS)
		&& pwdata[DVSC_CTRL_START_BIT] |=> busy && (r_r.step_count == 5'h00))
		else $error("step count not cleared at start");

	ovf_exit_a: assert property (
		busy && step_tick && first_op && adder_link_out
		|=> !busy && r_r.link && r_r.ovf && host_resume)
		else $error("overflow did not end divide with link set");

	last_flag_a: assert property (
		busy |-> div_last == ((r_r.step_count == DVSC_SC_LAST)
		|| ((r_r.step_count == DVSC_SC_FIRST) && adder_link_out)))
		else $error("last-step indicator wrong");

	div_gate_a: assert property (
		busy && (r_r.step_count < 5'h0D) |-> divisor_gate && (add_b == r_r.divisor))
		else $error("divisor not gated before final step");

	final_gate_a: assert property (
		busy && last_op |-> (divisor_gate == !r_r.quotient_reg[0]))
		else $error("final divisor gating wrong");

	sc_step_a: assert property (
		busy && step_tick && !div_last |=> r_r.step_count == $past(r_r.step_count) + 5'h01)
		else $error("step count did not advance by one");

	stop_timing_a: assert property (
		busy && step_tick && last_op |=> !busy ##1 !step_tick [*3])
		else $error("step timing kept running after count thirteen");

	link_clear_a: assert property (
		busy && step_tick && last_op && !first_op |=> !r_r.link && host_resume)
		else $error("link not cleared on final step");

	quot_first_a: assert property (
		busy && step_tick && first_op && !adder_link_out |=> !r_r.quotient_reg[0])
		else $error("first quotient bit not cleared");

	acc_hold_a: assert property (
		busy && step_tick && (r_r.step_count == 5'h0C)
		|=> r_r.acc == $past(add_sum[11:0]))
		else $error("accumulator shifted on step twelve");

	tick_only_a: assert property (
		busy && !step_tick |=> $stable(r_r.step_count) && $stable(r_r.quotient_reg))
		else $error("state changed without a step pulse");

	shift_in_a: assert property (
		busy && step_tick && !first_op && (r_r.step_count < DVSC_SC_ACC_HOLD)
		|=> r_r.acc[0] == ($past(r_r.quotient_reg[0]) ^ $past(r_r.quotient_reg[11])))
		else $error("accumulator shift-in bit wrong");

	link_path_a: assert property (
		busy && step_tick && !div_last
		|=> r_r.link == ($past(r_r.link) ^ $past(add_sum[12])))
		else $error("link not updated from adder link stage");

	quot_step_a: assert property (
		busy && step_tick && !first_op && !last_op
		|=> r_r.quotient_reg[0] == ($past(adder_link_out) ^ $past(r_r.quotient_reg[0])))
		else $error("quotient bit not formed from adder link");

	final_hold_a: assert property (
		busy && step_tick && last_op
		|=> (r_r.quotient_reg == $past(r_r.quotient_reg)) && (r_r.acc == $past(add_sum[11:0])))
		else $error("final step shifted or lost the correction");

	cov_normal_c: cover property (busy && step_tick && last_op ##1 host_resume);
	cov_acc_hold_c: cover property (busy && step_tick && (r_r.step_count == DVSC_SC_ACC_HOLD));
	cov_overflow_c: cover property (busy && step_tick && div_overflow);
	cov_apb_err_c: cover property (pready && pslverr);
	cov_final_wo_c: cover property (busy && last_op && r_r.quotient_reg[0]);

endmodule
`default_nettype wire

// *** verification/dvsc_host_model.sv ***
// Host processor side model: pauses while the divide runs, resumes on completion
`timescale 1ns/1ps
`default_nettype none
module dvsc_host_model (
	// Clock and reset
	input  wire logic pclk,
	input  wire logic presetn,
	// Divide unit handshake
	input  wire logic busy,
	input  wire logic host_resume,
	// Observations
	output var  int   resume_count,
	output var  int   busy_len
);
	int run_len;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			resume_count <= 0;
			busy_len <= 0;
			run_len <= 0;
		end else if (host_resume) begin
			// Host cycle timing restarts here
			resume_count <= resume_count + 1;
			busy_len <= run_len;
			run_len <= 0;
		end else if (busy) begin
			run_len <= run_len + 1;
		end
	end
endmodule
`default_nettype wire

// *** verification/testbench.sv ***
// Self-checking bench for the divide step control block
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin err_count++; \
	$display("CHECK FAILED t=%0t got %h exp %h", $time, a, b); end end
module testbench
	import dvsc_pkg::*;
;
	// Long enough that writes after a start still meet a running divide, even on overflow
	localparam int SD = 8;
	logic        pclk;
	logic        presetn;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        busy;
	logic        host_resume;
	int          resume_count;
	int          busy_len;
	int          err_count;
	int          check_count;
	int          seed;
	logic [31:0] r;
	logic        e;

	dvsc_divide_ctrl #(.STEP_DIV(SD)) i_dvsc_divide_ctrl (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .busy(busy),
		.host_resume(host_resume));
	dvsc_host_model i_dvsc_host_model (.pclk(pclk), .presetn(presetn), .busy(busy),
		.host_resume(host_resume), .resume_count(resume_count), .busy_len(busy_len));

	initial begin
		pclk = 1'b0;
		forever #10 pclk = ~pclk;
	end

	task automatic summarize();
		$display("checks %0d mismatches %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50) begin
			err_count++;
			summarize();
		end
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// Returns {ovf, link, acc, quot} after the full step sequence, or after step zero on overflow
	function automatic logic [25:0] ref_div(logic [11:0] a, q, d, logic l);
		logic [12:0] s;
		logic        al;
		logic        cm;
		logic        g;
		logic        qb;
		for (int sc = 0; sc < 14; sc++) begin
			cm = (sc == 0) || ((sc < 13) ? (q[1] != q[0]) : q[1]);
			g = (sc < 13) || !q[0];
			s = {1'b0, cm ? ~a : a} + {1'b0, g ? d : 12'h000};
			al = l ^ s[12];
			if (sc == 0 && al) begin
				return {2'b11, a, q};
			end
			qb = (sc == 0) ? 1'b0 : (al ^ q[0]);
			a = (sc < 12) ? {s[10:0], (sc == 0) ? 1'b0 : (q[0] ^ q[11])} : s[11:0];
			if (sc < 13) begin
				q = {q[10:0], qb};
				l = al;
			end else begin
				l = 1'b0;
			end
		end
		return {1'b0, l, a, q};
	endfunction

	task automatic divide(input logic [11:0] a, q, d, input logic l);
		logic [25:0] x;
		int          rc;
		int          n;
		x = ref_div(a, q, d, l);
		rc = resume_count;
		apb(1'b1, DVSC_ACC_OFS, {20'h0, a});
		apb(1'b1, DVSC_QUOT_OFS, {20'h0, q});
		apb(1'b1, DVSC_DIVS_OFS, {20'h0, d});
		apb(1'b1, DVSC_LINK_OFS, {31'h0, l});
		apb(1'b1, DVSC_CTRL_OFS, 32'h1);
		// Writes and a second start while running must be dropped
		apb(1'b1, DVSC_ACC_OFS, 32'h0000_0ABC);
		apb(1'b1, DVSC_CTRL_OFS, 32'h1);
		n = 0;
		while (resume_count == rc && n < 400) begin
			@(posedge pclk);
			n++;
		end
		if (n >= 400) begin
			err_count++;
			summarize();
		end
		repeat (4) @(posedge pclk);
		`CHK(resume_count, rc + 1)
		`CHK(busy_len, x[25] ? SD + 1 : 14 * SD + 1)
		apb(1'b0, DVSC_LINK_OFS, 32'h0);
		`CHK(r, {31'h0, x[24]})
		apb(1'b0, DVSC_STATUS_OFS, 32'h0);
		`CHK(r, {19'h0, x[25] ? 5'h01 : DVSC_SC_LAST, 6'h00, x[25], 1'b0})
		// Overflow leaves both halves of the dividend untouched
		apb(1'b0, DVSC_ACC_OFS, 32'h0);
		`CHK(r, {20'h0, x[23:12]})
		apb(1'b0, DVSC_QUOT_OFS, 32'h0);
		`CHK(r, {20'h0, x[11:0]})
		$display("test divide %h %h by %h done", a, q, d);
	endtask

	initial begin
		seed = 32'h6736;
		err_count = 0;
		check_count = 0;
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		for (int i = 0; i < 6; i++) begin
			apb(1'b0, 8'(4 * i), 32'h0);
			`CHK(r, 32'h0)
		end
		apb(1'b1, 8'h18, 32'hFFFF_FFFF);
		`CHK(e, 1'b1)
		apb(1'b0, 8'h18, 32'h0);
		`CHK({e, r}, {1'b1, 32'h0})
		$display("test reset_map done");
		divide(12'h000, 12'h091, 12'h00C, 1'b0);
		divide(12'h000, 12'h000, 12'h000, 1'b0);
		divide(12'hFFF, 12'hFFF, 12'hFFF, 1'b1);
		divide(12'h005, 12'h800, 12'h00C, 1'b0);
		// Reset in the middle of a divide, then the block must come back clean
		apb(1'b1, DVSC_ACC_OFS, 32'h0000_0123);
		apb(1'b1, DVSC_CTRL_OFS, 32'h1);
		repeat (5) @(posedge pclk);
		`CHK(busy, 1'b1)
		presetn <= 1'b0;
		repeat (3) @(posedge pclk);
		`CHK(busy, 1'b0)
		presetn <= 1'b1;
		apb(1'b0, DVSC_STATUS_OFS, 32'h0);
		`CHK(r, 32'h0)
		apb(1'b0, DVSC_ACC_OFS, 32'h0);
		`CHK(r, 32'h0)
		$display("test mid_reset done");
		for (int i = 0; i < 10; i++) begin
			divide(12'($random(seed)), 12'($random(seed)), 12'($random(seed)),
				1'($random(seed)));
		end
		summarize();
	end
endmodule
`default_nettype wire
